// *** rtl/i2c_addr_pkg.sv ***
// constants for the two-wire slave address match block
package i2c_addr_pkg;
  localparam logic [6:0] OWN_ADDR_RST   = 7'h08;
  localparam logic [6:0] OWN_ADDR_MAX   = 7'h7F;
  localparam int         SYS_CLK_HZ     = 50_000_000;
  localparam int         OVS_NORMAL     = 16;
  localparam int         OVS_SLOW       = 32;
  localparam int         RATE_50K       = 50_000;
  localparam int         RATE_100K      = 100_000;
  localparam int         RATE_400K      = 400_000;
  localparam int         RATE_1000K     = 1_000_000;
  localparam logic [1:0] RATE_SEL_50K   = 2'h0;
  localparam logic [1:0] RATE_SEL_100K  = 2'h1;
  localparam logic [1:0] RATE_SEL_400K  = 2'h2;
  localparam logic [1:0] RATE_SEL_1000K = 2'h3;
  localparam int DIV_50K   = SYS_CLK_HZ / (RATE_50K * OVS_SLOW);
  localparam int DIV_100K  = SYS_CLK_HZ / (RATE_100K * OVS_NORMAL);
  localparam int DIV_400K  = SYS_CLK_HZ / (RATE_400K * OVS_NORMAL);
  localparam int DIV_1000K = SYS_CLK_HZ / (RATE_1000K * OVS_NORMAL);
  localparam logic [1:0] MODE_SLAVE     = 2'h0;
  localparam logic [1:0] MODE_MASTER    = 2'h1;
  localparam logic [1:0] MODE_MULTI     = 2'h2;
  localparam logic [1:0] MODE_MULTI_SLV = 2'h3;
  localparam logic [1:0] PINS_ANY       = 2'h0;
  localparam logic [1:0] PINS_SET_A     = 2'h1;
  localparam logic [1:0] PINS_SET_B     = 2'h2;
endpackage : i2c_addr_pkg

// *** rtl/i2c_addr_match.sv ***
// two-wire slave front end: oversampling, address recognition, stretch, wake
//
// Notes on behaviour
// - the first byte after a start is compared with a 7-bit right-justified own address, reset value 8.
// - when the mode holds no slave operation the own address is ignored and nothing is recognised.
// - ten-bit addresses are not decoded here; software decode must be used and the cpu checks byte two.
// - under hardware decode a foreign address is refused with a not-acknowledge, no cpu involved.
// - under hardware decode an own address raises the cpu event and holds the clock line low until serviced.
// - wake on match works only with hardware decode and a dedicated pin set.
// - wake on match is off after reset unless enabled and must be armed on entry to sleep.
// - the fixed build divides the system clock to oversample by 32 at 50 kbps and 16 otherwise.
// - with the external enable option the pins split into inputs and low-drive outputs.
// - direction is named from the master: the read/write bit high means the master reads.
// - the active-high reset input holds the block idle and releases the bus; the port has no default value.
// - in split use the clock low-drive output holds the clock line low during a stall.
`timescale 1ns/10ps
module i2c_addr_match #(
  parameter bit FIXED_BUILD = 1'h1,
  parameter bit EXT_OE      = 1'h0
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       blk_reset,
  input  wire logic       ovs_clk_en,
  input  wire logic [1:0] rate_sel,
  input  wire logic [1:0] mode_sel,
  input  wire logic [6:0] own_addr,
  input  wire logic       sw_decode,
  input  wire logic [1:0] pin_set,
  input  wire logic       wake_enable,
  input  wire logic       sleep_req,
  input  wire logic       cpu_ack,
  input  wire logic       cpu_nak,
  input  wire logic       sda_in,
  input  wire logic       scl_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic            scl_out,
  output logic            scl_oe,
  output logic            sda_drv_low,
  output logic            scl_drv_low,
  output logic            addr_event,
  output logic [7:0]      addr_byte,
  output logic            master_reads,
  output logic            addr_busy,
  output logic            wake_out
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_WAIT_CPU,
    ST_ACK,
    ST_ACK_END,
    ST_SKIP
  } state_t;

  localparam int LINE_SDA = 0;
  localparam int LINE_SCL = 1;

  // refuse divider counts that the 8-bit divider cannot hold
  if (i2c_addr_pkg::DIV_50K < 1 || i2c_addr_pkg::DIV_50K > 256) begin : g_bad_div_50k
    $error("slow rate divider out of range");
  end
  if (i2c_addr_pkg::DIV_100K < 1 || i2c_addr_pkg::DIV_100K > 256) begin : g_bad_div_100k
    $error("standard rate divider out of range");
  end
  if (i2c_addr_pkg::DIV_400K < 1 || i2c_addr_pkg::DIV_400K > 256) begin : g_bad_div_400k
    $error("fast rate divider out of range");
  end
  if (i2c_addr_pkg::DIV_1000K < 1 || i2c_addr_pkg::DIV_1000K > 256) begin : g_bad_div_1000k
    $error("top rate divider out of range");
  end

  logic       held;
  logic [7:0] div_q;
  logic [7:0] div_d;
  logic [7:0] div_top;
  logic       div_wrap;
  logic       tick;
  logic [1:0] line_in;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] samp_q;
  logic [1:0] samp_d;
  logic       sda_now;
  logic       scl_now;
  logic       sda_samp;
  logic       scl_samp;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       slave_mode;
  logic       addr_hit;
  logic       byte_done;
  logic       dedicated;
  logic       wake_ok;
  logic       enter_shift;
  logic       take_bit;
  logic       load_byte;
  logic       match_end;
  state_t     state_q;
  state_t     state_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [3:0] bit_cnt_q;
  logic [3:0] bit_cnt_d;
  logic       event_q;
  logic       event_d;
  logic [7:0] abyte_q;
  logic [7:0] abyte_d;
  logic       stretch_q;
  logic       stretch_d;
  logic       ack_low_q;
  logic       ack_low_d;
  logic       wake_armed_q;
  logic       wake_armed_d;
  logic       wake_q;
  logic       wake_d;

  assign held = blk_reset;

  // oversampling tick: fixed build divides the system clock, the other takes an enable
  assign div_top  = (rate_sel == i2c_addr_pkg::RATE_SEL_50K)  ? 8'(i2c_addr_pkg::DIV_50K - 1) :
                    (rate_sel == i2c_addr_pkg::RATE_SEL_100K) ? 8'(i2c_addr_pkg::DIV_100K - 1) :
                    (rate_sel == i2c_addr_pkg::RATE_SEL_400K) ? 8'(i2c_addr_pkg::DIV_400K - 1) :
                    8'(i2c_addr_pkg::DIV_1000K - 1);
  assign div_wrap = (div_q >= div_top);
  assign div_d    = (held || div_wrap) ? 8'h00 : div_q + 8'h01;
  assign tick     = FIXED_BUILD ? (div_q == div_top) : ovs_clk_en;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_d;
    end
  end

  assign line_in = {scl_in, sda_in};

  // two-stage synchroniser per line, then a sample taken at each tick
  for (genvar i = 0; i < 2; i++) begin : g_sync
    assign samp_d[i] = tick ? sync2_q[i] : samp_q[i];
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sync1_q[i] <= 1'h1;
        sync2_q[i] <= 1'h1;
        samp_q[i]  <= 1'h1;
      end else begin
        sync1_q[i] <= line_in[i];
        sync2_q[i] <= sync1_q[i];
        samp_q[i]  <= samp_d[i];
      end
    end
  end

  assign sda_now  = sync2_q[LINE_SDA];
  assign scl_now  = sync2_q[LINE_SCL];
  assign sda_samp = samp_q[LINE_SDA];
  assign scl_samp = samp_q[LINE_SCL];

  assign scl_rise   = tick && !scl_samp && scl_now;
  assign scl_fall   = tick && scl_samp && !scl_now;
  assign start_cond = tick && scl_now && scl_samp && sda_samp && !sda_now;
  assign stop_cond  = tick && scl_now && scl_samp && !sda_samp && sda_now;

  assign slave_mode  = (mode_sel == i2c_addr_pkg::MODE_SLAVE) ||
                       (mode_sel == i2c_addr_pkg::MODE_MULTI_SLV);
  assign addr_hit    = (shift_q[7:1] == own_addr);
  assign byte_done   = (bit_cnt_q == 4'h8);
  assign dedicated   = (pin_set == i2c_addr_pkg::PINS_SET_A) ||
                       (pin_set == i2c_addr_pkg::PINS_SET_B);
  assign wake_ok     = wake_enable && !sw_decode && dedicated;
  assign enter_shift = start_cond && (state_d == ST_SHIFT);
  assign take_bit    = (state_q == ST_SHIFT) && scl_rise && !byte_done;
  assign load_byte   = (state_q == ST_SHIFT) && (state_d == ST_WAIT_CPU);
  assign match_end   = (state_q == ST_SHIFT) && byte_done && addr_hit;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start_cond && slave_mode) begin
          state_d = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (byte_done && sw_decode) begin
          state_d = ST_WAIT_CPU;
        end else if (byte_done && addr_hit) begin
          state_d = ST_WAIT_CPU;
        end else if (byte_done) begin
          state_d = ST_SKIP;
        end
      end
      ST_WAIT_CPU: begin
        if (cpu_ack) begin
          state_d = ST_ACK;
        end else if (cpu_nak) begin
          state_d = ST_SKIP;
        end
      end
      ST_ACK: begin
        if (scl_rise) begin
          state_d = ST_ACK_END;
        end
      end
      ST_ACK_END: begin
        if (scl_fall) begin
          state_d = ST_IDLE;
        end
      end
      ST_SKIP: begin
        state_d = ST_SKIP;
      end
    endcase
    if (stop_cond || (start_cond && state_q != ST_IDLE)) begin
      state_d = (start_cond && slave_mode) ? ST_SHIFT : ST_IDLE;
    end
    if (!slave_mode || held) begin
      state_d = ST_IDLE;
    end
  end

  // next values; sda stays low through the whole ninth clock so no false stop appears
  assign bit_cnt_d    = (held || enter_shift) ? 4'h0 :
                        take_bit ? bit_cnt_q + 4'h1 : bit_cnt_q;
  assign shift_d      = take_bit ? {shift_q[6:0], sda_now} : shift_q;
  assign abyte_d      = load_byte ? shift_q : abyte_q;
  assign event_d      = load_byte;
  assign stretch_d    = (state_d == ST_WAIT_CPU) && !scl_samp;
  assign ack_low_d    = (state_d == ST_ACK) || (state_d == ST_ACK_END);
  assign wake_armed_d = (held || !sleep_req) ? 1'h0 : (wake_ok ? 1'h1 : wake_armed_q);
  assign wake_d       = !held && wake_armed_q && sleep_req && !sw_decode && match_end;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 8'h00;
    end else begin
      shift_q <= shift_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 4'h0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_q <= 1'h0;
    end else begin
      event_q <= event_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      abyte_q <= 8'h00;
    end else begin
      abyte_q <= abyte_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stretch_q <= 1'h0;
    end else begin
      stretch_q <= stretch_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_low_q <= 1'h0;
    end else begin
      ack_low_q <= ack_low_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_armed_q <= 1'h0;
    end else begin
      wake_armed_q <= wake_armed_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_q <= 1'h0;
    end else begin
      wake_q <= wake_d;
    end
  end

  assign sda_drv_low  = ack_low_q;
  assign scl_drv_low  = stretch_q;
  assign sda_out      = 1'h0;
  assign scl_out      = 1'h0;
  assign sda_oe       = EXT_OE ? 1'h0 : ack_low_q;
  assign scl_oe       = EXT_OE ? 1'h0 : stretch_q;
  assign addr_event   = event_q;
  assign addr_byte    = abyte_q;
  assign master_reads = abyte_q[0];
  assign addr_busy    = (state_q != ST_IDLE);
  assign wake_out     = wake_q;
endmodule : i2c_addr_match

// *** verif/i2c_addr_chk.sv ***
// assertion checker for the address match block
`timescale 1ns/10ps
module i2c_addr_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       blk_reset,
  input wire logic [1:0] mode_sel,
  input wire logic [6:0] own_addr,
  input wire logic       sw_decode,
  input wire logic       sleep_req,
  input wire logic       cpu_ack,
  input wire logic       cpu_nak,
  input wire logic       scl_drv_low,
  input wire logic       sda_drv_low,
  input wire logic       addr_event,
  input wire logic [7:0] addr_byte,
  input wire logic       master_reads,
  input wire logic       wake_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire dec = cpu_ack | cpu_nak | blk_reset;
  own_match_a: assert property (addr_event && !sw_decode |-> addr_byte[7:1] == own_addr)
    else $error("foreign address handed on");
  slave_only_a: assert property (addr_event |-> mode_sel[1] == mode_sel[0])
    else $error("event outside slave mode");
  dir_bit_a: assert property (addr_event |-> master_reads == addr_byte[0])
    else $error("direction flag wrong");
  event_pulse_a: assert property (addr_event |=> !addr_event)
    else $error("event longer than one cycle");
  hold_start_a: assert property (addr_event |-> ##[1:60] scl_drv_low)
    else $error("clock not held after event");
  hold_keep_a: assert property ($fell(scl_drv_low) |-> $past(dec) || $past(dec, 2))
    else $error("clock released without decision");
  wake_gate_a: assert property (wake_out |-> !sw_decode && sleep_req)
    else $error("wake outside armed sleep");
  blk_quiet_a: assert property (blk_reset |=> !scl_drv_low && !sda_drv_low && !addr_event)
    else $error("bus driven in block reset");
  ack_after_cpu_a: assert property ($rose(sda_drv_low) |-> $past(cpu_ack))
    else $error("acknowledge without cpu decision");
endmodule : i2c_addr_chk
bind i2c_addr_match i2c_addr_chk u_chk (.clk(clk), .rst_n(rst_n), .blk_reset(blk_reset),
  .mode_sel(mode_sel), .own_addr(own_addr), .sw_decode(sw_decode), .sleep_req(sleep_req),
  .cpu_ack(cpu_ack), .cpu_nak(cpu_nak), .scl_drv_low(scl_drv_low), .sda_drv_low(sda_drv_low),
  .addr_event(addr_event), .addr_byte(addr_byte), .master_reads(master_reads),
  .wake_out(wake_out));

// *** verif/bus_master_model.sv ***
// bus master model driving the two-wire lines
`timescale 1ns/10ps
module bus_master_model (
  input wire logic clk,
  input wire logic scl_line,
  input wire logic sda_line,
  output logic     scl_o = 1'h1,
  output logic     sda_o = 1'h1
);
  localparam time HALF = 500ns; // nominal 1000 kbps, never faster
  task automatic start_cond();
    sda_o = 1'h0;
    #HALF scl_o = 1'h0;
  endtask : start_cond
  task automatic xfer(input logic b, output logic r);
    int n;
    sda_o = b;
    #HALF scl_o = 1'h1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (scl_line !== 1'h1 && n < 3000);
    r = sda_line;
    #HALF scl_o = 1'h0;
  endtask : xfer
  task automatic stop_cond();
    sda_o = 1'h0;
    #HALF scl_o = 1'h1;
    #HALF sda_o = 1'h1;
    #HALF;
  endtask : stop_cond
endmodule : bus_master_model

// *** verif/i2c_addr_match_bench.sv ***
// self-checking bench for the address match block
`timescale 1ns/10ps
module i2c_addr_match_bench;
  logic clk = 1'h0, rst_n = 1'h0, blk_reset = 1'h0, cpu_ack = 1'h0, cpu_nak = 1'h0;
  logic sw_decode = 1'h0, wake_enable = 1'h0, sleep_req = 1'h0, ev_seen = 1'h0, wake_seen = 1'h0;
  logic [1:0] mode_sel = 2'h0, pin_set = 2'h0, rate_sel = 2'h3;
  logic [6:0] own_addr = 7'h08;
  logic [7:0] addr_byte, cap;
  wire m_scl, m_sda, scl_drv_low, sda_drv_low, addr_event, master_reads, addr_busy, wake_out;
  wire scl_out, scl_oe, sda_out, sda_oe;
  wire scl_in = m_scl & ~scl_drv_low;
  wire sda_in = m_sda & ~sda_drv_low;
  int failures = 0, check_count = 0, cycles = 0;
  always #10ns clk = ~clk;
  i2c_addr_match uut (.clk(clk), .rst_n(rst_n), .blk_reset(blk_reset),
    .ovs_clk_en(1'h0), // fixed build makes its own tick
    .rate_sel(rate_sel), .mode_sel(mode_sel), .own_addr(own_addr), .sw_decode(sw_decode),
    .pin_set(pin_set), .wake_enable(wake_enable), .sleep_req(sleep_req), .cpu_ack(cpu_ack),
    .cpu_nak(cpu_nak), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_drv_low(sda_drv_low), .scl_drv_low(scl_drv_low),
    .addr_event(addr_event), .addr_byte(addr_byte), .master_reads(master_reads),
    .addr_busy(addr_busy), .wake_out(wake_out));
  bus_master_model m (.clk(clk), .scl_line(scl_in), .sda_line(sda_in), .scl_o(m_scl),
    .sda_o(m_sda));
  always @(posedge clk) begin
    if (addr_event === 1'h1) begin
      ev_seen <= 1'h1;
      cap <= addr_byte;
    end
    if (wake_out === 1'h1) wake_seen <= 1'h1;
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic chk(input logic ok, input string what);
    check_count++;
    if (ok !== 1'h1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic go(input logic [7:0] b, input logic ev, ack, hr, nak_bit);
    logic r;
    ev_seen = 1'h0;
    m.start_cond();
    for (int i = 7; i >= 0; i--) m.xfer(b[i], r);
    repeat (20) @(negedge clk);
    chk(ev_seen === ev, "address event");
    if (ev) begin
      chk(cap === b && master_reads === b[0], "captured address");
      chk(scl_drv_low === 1'h1 && scl_oe === 1'h1 && addr_busy === 1'h1, "clock held");
      if (hr) blk_reset = 1'h1;
      else if (ack) cpu_ack = 1'h1;
      else cpu_nak = 1'h1;
      @(negedge clk);
      {blk_reset, cpu_ack, cpu_nak} = 3'h0;
      @(negedge clk);
      if (hr) chk({scl_drv_low, sda_drv_low} === 2'h0, "reset release");
      if (ack && !hr) chk({sda_drv_low, sda_oe} === 2'h3, "ack drive");
    end
    m.xfer(1'h1, r);
    chk(r === nak_bit, "acknowledge bit");
    m.stop_cond();
    repeat (10) @(negedge clk);
    chk({addr_busy, sda_oe, scl_out, sda_out} === 4'h0, "idle after stop");
  endtask : go
  task automatic t_own_read();
    go(8'h11, 1'h1, 1'h1, 1'h0, 1'h0);
    chk(wake_seen === 1'h0, "no wake while awake");
  endtask : t_own_read
  task automatic t_foreign();
    go(8'hFE, 1'h0, 1'h0, 1'h0, 1'h1);
  endtask : t_foreign
  task automatic t_soft();
    sw_decode = 1'h1;
    go(8'hF0, 1'h1, 1'h0, 1'h0, 1'h1);
    sw_decode = 1'h0;
  endtask : t_soft
  task automatic t_modes();
    for (int k = 0; k < 4; k++) begin
      mode_sel = 2'(k);
      go(8'h10, k == 0 || k == 3, 1'h1, 1'h0, !(k == 0 || k == 3));
    end
    mode_sel = 2'h0;
  endtask : t_modes
  task automatic t_wake();
    {pin_set, wake_enable, sleep_req, wake_seen} = 5'h0E;
    go(8'h10, 1'h1, 1'h1, 1'h0, 1'h0);
    chk(wake_seen === 1'h1, "wake on match");
    wake_seen = 1'h0;
    go(8'hFE, 1'h0, 1'h0, 1'h0, 1'h1);
    chk(wake_seen === 1'h0, "wake on foreign address");
    {pin_set, wake_enable, sleep_req} = 4'h0;
  endtask : t_wake
  task automatic t_rate();
    rate_sel = 2'h2;
    go(8'h10, 1'h1, 1'h1, 1'h0, 1'h0);
    rate_sel = 2'h3;
  endtask : t_rate
  task automatic t_blk();
    go(8'h10, 1'h1, 1'h0, 1'h1, 1'h1);
  endtask : t_blk
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'h1;
    repeat (5) @(negedge clk);
    t_own_read();
    t_foreign();
    t_soft();
    t_modes();
    t_wake();
    t_blk();
    t_rate();
    wrap_up();
  end
endmodule : i2c_addr_match_bench
